// >>> fsr_map.svh
/*
 * register indices, field positions, reset values and counts of the
 * fault and status register bank.
 * assumes a 32-bit apb slave with one register per aligned word.
 */
`ifndef FSR_MAP_SVH
`define FSR_MAP_SVH

// register indices; the byte address is four times the index
`define FSR_IDX_SUMMARY     6'h00
`define FSR_IDX_LS_LOW      6'h01
`define FSR_IDX_LS_HIGH     6'h02
`define FSR_IDX_MISC        6'h03
`define FSR_IDX_COUNT       6'h04
`define FSR_IDX_WATCHDOG    6'h05
`define FSR_IDX_RELAY       6'h06
`define FSR_IDX_CH_FIRST    6'h07
`define FSR_IDX_CH_LAST     6'h0e
`define FSR_IDX_WS_SUPPLY   6'h0f
`define FSR_IDX_WD_CTRL     6'h11

// address split
`define FSR_ADDR_W          8
`define FSR_IDX_MSB         7
`define FSR_IDX_LSB         2

// field positions inside the byte of a register
`define FSR_BIT_POWER_UP    1
`define FSR_BIT_HS_FAULT    6
`define FSR_BIT_WD_EN       4
`define FSR_BIT_WD_ERROR    7
`define FSR_BIT_OV_REPLICA  7
`define FSR_BIT_CONFLICT    5
`define FSR_BIT_OVERFLOW    7

// reset values
`define FSR_POWER_UP_RESET  1'b1
`define FSR_WD_EN_RESET     1'b0
`define FSR_COUNT_RESET     8'h00

// counter limits and widths
`define FSR_COUNT_MAX       8'hff
`define FSR_COUNT_STEP      8'h01
`define FSR_UPPER_ZERO      24'h000000
`define FSR_BYTE_ZERO       8'h00

`endif

// >>> fsr_pkg.sv
/*
 * types shared by the fault and status register bank.
 * assumes fsr_map.svh supplies the numeric constants.
 */
package fsr_pkg;

    typedef logic [7:0] fsr_byte_t;
    typedef logic [5:0] fsr_idx_t;
    typedef logic [7:0] fsr_addr_t;

    // apb phase tracker, one-hot
    typedef enum logic [2:0] {
        FSR_PH_IDLE   = 3'b001,
        FSR_PH_SETUP  = 3'b010,
        FSR_PH_ACCESS = 3'b100
    } fsr_phase_e;

endpackage

// >>> fsr_status_bank.sv
/*
 * fault and status register bank of a braking power controller, read
 * over apb; status bits come from the analog monitors as plain levels.
 * assumes every monitor input is synchronous to SYS_CLK and that the
 * apb master holds a request stable until pready.
 */
// Overview of operation
// - summary low-side bit is the or of every digital or pwm driver fault
// - power-up flag sets on power-on reset, clears when software reads it
// - two relay comparator bits show the live comparator levels
// - external reset bit is high while the reset pin is pulled low outside
// - overvoltage replica bit always equals the overvoltage bit
// - high-side summary sets on any master or pump relay fault
// - high-side summary stays latched until register 6 is read
// - each low-side output has an open-load flag; 9 and 10 are the lamps
// - each low-side output has a short-to-battery flag; 9 and 10 are lamps
// - counter conflict flags count enable and count clear both high
// - k-line current limit bit is high during current limiting
// - overflow flag sets when the speed counter counts past 256
// - each speed channel reports its count of valid sensor data bits
// - three-bit watchdog tracking count is readable, lowest bit lsb
// - watchdog status reads 1 in range while enabled, 0 out of range or disabled
// - each sensor supply flags open load or short, and overcurrent
// - master relay overcurrent, short to ground and leakage flags
// - flag when the master relay gate is forced off from outside
// - flag when the pump relay gate is forced off from outside
// - pump relay short to ground and overcurrent flags
// - decoded sensor data of speed channel 1 is readable
// - watchdog error latches when out of range and clears on read
`timescale 1ns/1ps
`include "fsr_map.svh"

module fsr_status_bank (
    input wire logic SYS_CLK, // 200 mhz system clock
    input wire logic RESET, // synchronous, active high
    input wire logic PSEL, // apb select
    input wire logic PENABLE, // apb access phase
    input wire logic PWRITE, // apb direction, high for write
    input wire fsr_pkg::fsr_addr_t PADDR, // apb byte address
    input wire logic [31:0] PWDATA, // apb write data
    output logic [31:0] PRDATA, // apb read data, registered
    output logic PREADY, // apb ready
    output logic PSLVERR, // apb error on unmapped address
    input wire logic [9:0] OPEN_LOAD_FLAG, // bit n is output n+1
    input wire logic [9:0] SHORT_TO_BATTERY_FLAG, // bit n is output n+1
    input wire logic POWER_ON_EVENT, // power-on reset seen
    input wire logic RESET_PIN_EXT_LOW, // reset pin pulled low outside
    input wire logic BAT_UNDERVOLTAGE, // battery undervoltage
    input wire logic BAT_OVERVOLTAGE, // battery overvoltage
    input wire logic RELAY_COMPARATOR_A, // comparator 1 output level
    input wire logic RELAY_COMPARATOR_B, // comparator 2 output level
    input wire logic MASTER_RELAY_OVERCURRENT, // master relay overcurrent
    input wire logic MASTER_RELAY_SHORT_GROUND, // master relay short
    input wire logic MASTER_RELAY_LEAKAGE, // master relay load leakage
    input wire logic MASTER_GATE_FORCED_OFF, // master gate off from outside
    input wire logic PUMP_GATE_FORCED_OFF, // pump gate off from outside
    input wire logic PUMP_RELAY_SHORT_GROUND, // pump relay short
    input wire logic PUMP_RELAY_OVERCURRENT, // pump relay overcurrent
    input wire logic KLINE_CURRENT_LIMIT, // k-line in current limit
    input wire logic OVERTEMPERATURE_FLAG, // any overtemperature
    input wire logic COUNT_ENABLE_CTL, // speed counter enable
    input wire logic COUNT_CLEAR_CTL, // speed counter clear
    input wire logic SPEED_PULSE, // one-cycle wheel-speed edge
    input wire logic [2:0] WATCHDOG_TRACK_COUNT, // watchdog tracking count
    input wire logic WATCHDOG_TIMING_OK, // watchdog timing in range
    input wire logic [1:0] SUPPLY_OPEN_OR_SHORT, // supplies one and two
    input wire logic [1:0] SUPPLY_OVERCURRENT, // supplies one and two
    input wire logic [3:0][8:0] CHANNEL_SENSOR_DATA, // decoded data per channel
    input wire logic [3:0][3:0] SENSOR_VALID_BITS_FIELD, // valid bit count
    input wire logic [3:0] CHANNEL_NEW, // new data per channel
    input wire logic [3:0] CHANNEL_STANDSTILL, // standstill mode per channel
    input wire logic [3:0] CHANNEL_SHORT_BAT, // channel short to battery
    input wire logic [3:0] CHANNEL_FAULT, // channel open or short
    input wire logic [3:0] CHANNEL_OVERCURRENT, // channel overcurrent
    output logic WATCHDOG_ENABLE // watchdog enable, from register
);
    import fsr_pkg::*;

    fsr_phase_e phase;
    fsr_idx_t idx;
    fsr_byte_t live;
    fsr_byte_t ch_data [4];
    fsr_byte_t ch_ctrl [4];
    fsr_idx_t ch_off;
    logic rd_setup;
    logic rd_access;
    logic wr_access;
    logic mapped;
    logic power_up_flag;
    logic highside_any_fault;
    logic hs_seen;
    logic watchdog_latched_error;
    logic watchdog_in_range;
    logic ls_fail;
    logic hs_event;
    logic speed_counter_conflict;
    logic speed_counter_overflow;
    logic [7:0] speed_count;

    // address decode, shared by the error answer and the read mux
    function automatic logic is_mapped(input fsr_idx_t i, input logic [1:0] low);
        is_mapped = (low == 2'b00) &&
                    ((i <= `FSR_IDX_WS_SUPPLY) || (i == `FSR_IDX_WD_CTRL));
    endfunction

    assign idx = PADDR[`FSR_IDX_MSB:`FSR_IDX_LSB];
    assign mapped = is_mapped(idx, PADDR[1:0]);
    assign rd_setup = PSEL && !PENABLE && !PWRITE;
    assign rd_access = PSEL && PENABLE && !PWRITE && (phase == FSR_PH_ACCESS);
    assign wr_access = PSEL && PENABLE && PWRITE && (phase == FSR_PH_ACCESS);

    // apb phase; no wait states, data is loaded in the setup cycle
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            phase <= FSR_PH_IDLE;
        end else begin
            case (phase)
                FSR_PH_IDLE,
                FSR_PH_SETUP: phase <= (PSEL && !PENABLE) ? FSR_PH_ACCESS : FSR_PH_IDLE;
                FSR_PH_ACCESS: phase <= (PSEL && !PENABLE) ? FSR_PH_ACCESS : FSR_PH_IDLE;
                default: phase <= FSR_PH_IDLE;
            endcase
        end
    end

    // handshake answers are combinational off the phase
    assign PREADY = (phase == FSR_PH_ACCESS);
    assign PSLVERR = (phase == FSR_PH_ACCESS) && PSEL && PENABLE && !mapped;

    // live summaries
    assign ls_fail = |OPEN_LOAD_FLAG[7:0] | |SHORT_TO_BATTERY_FLAG[7:0];
    assign hs_event = MASTER_RELAY_OVERCURRENT | MASTER_RELAY_SHORT_GROUND |
                      MASTER_RELAY_LEAKAGE | MASTER_GATE_FORCED_OFF |
                      PUMP_GATE_FORCED_OFF | PUMP_RELAY_SHORT_GROUND |
                      PUMP_RELAY_OVERCURRENT;
    assign speed_counter_conflict = COUNT_ENABLE_CTL & COUNT_CLEAR_CTL;
    // status reads 0 whenever the watchdog is disabled
    assign watchdog_in_range = WATCHDOG_ENABLE & WATCHDOG_TIMING_OK;

    // per-channel sensor words, one pair of registers each
    generate
        for (genvar ch = 0; ch < 4; ch++) begin : g_chan
            assign ch_data[ch] = CHANNEL_SENSOR_DATA[ch][7:0];
            assign ch_ctrl[ch] = {SENSOR_VALID_BITS_FIELD[ch], CHANNEL_SHORT_BAT[ch],
                                  CHANNEL_STANDSTILL[ch], CHANNEL_NEW[ch],
                                  CHANNEL_SENSOR_DATA[ch][8]};
        end
    endgenerate

    // read mux; live bits are sampled at the setup edge of the read
    always_comb begin
        live = `FSR_BYTE_ZERO;
        ch_off = idx - `FSR_IDX_CH_FIRST;
        case (idx)
            `FSR_IDX_SUMMARY: live = {RELAY_COMPARATOR_B, highside_any_fault,
                                      BAT_OVERVOLTAGE, BAT_UNDERVOLTAGE,
                                      RESET_PIN_EXT_LOW, RELAY_COMPARATOR_A,
                                      power_up_flag, ls_fail};
            `FSR_IDX_LS_LOW: live = {OPEN_LOAD_FLAG[3], SHORT_TO_BATTERY_FLAG[3],
                                     OPEN_LOAD_FLAG[2], SHORT_TO_BATTERY_FLAG[2],
                                     OPEN_LOAD_FLAG[1], SHORT_TO_BATTERY_FLAG[1],
                                     OPEN_LOAD_FLAG[0], SHORT_TO_BATTERY_FLAG[0]};
            `FSR_IDX_LS_HIGH: live = {OPEN_LOAD_FLAG[7], SHORT_TO_BATTERY_FLAG[7],
                                      OPEN_LOAD_FLAG[6], SHORT_TO_BATTERY_FLAG[6],
                                      OPEN_LOAD_FLAG[5], SHORT_TO_BATTERY_FLAG[5],
                                      OPEN_LOAD_FLAG[4], SHORT_TO_BATTERY_FLAG[4]};
            // lamp drivers one and two are outputs 9 and 10
            `FSR_IDX_MISC: live = {speed_counter_overflow, OVERTEMPERATURE_FLAG,
                                   speed_counter_conflict, KLINE_CURRENT_LIMIT,
                                   OPEN_LOAD_FLAG[9], SHORT_TO_BATTERY_FLAG[9],
                                   OPEN_LOAD_FLAG[8], SHORT_TO_BATTERY_FLAG[8]};
            `FSR_IDX_COUNT: live = speed_count;
            `FSR_IDX_WATCHDOG: live = {SUPPLY_OVERCURRENT[1], SUPPLY_OVERCURRENT[0],
                                       SUPPLY_OPEN_OR_SHORT[1], SUPPLY_OPEN_OR_SHORT[0],
                                       watchdog_in_range, WATCHDOG_TRACK_COUNT};
            `FSR_IDX_RELAY: live = {BAT_OVERVOLTAGE, PUMP_RELAY_OVERCURRENT,
                                    PUMP_RELAY_SHORT_GROUND, PUMP_GATE_FORCED_OFF,
                                    MASTER_RELAY_LEAKAGE, MASTER_GATE_FORCED_OFF,
                                    MASTER_RELAY_SHORT_GROUND,
                                    MASTER_RELAY_OVERCURRENT};
            `FSR_IDX_WS_SUPPLY: live = {CHANNEL_OVERCURRENT, CHANNEL_FAULT};
            `FSR_IDX_WD_CTRL: live = {watchdog_latched_error, 2'b00, WATCHDOG_ENABLE,
                                      4'h0};
            default: begin
                if (idx >= `FSR_IDX_CH_FIRST && idx <= `FSR_IDX_CH_LAST) begin
                    live = ch_off[0] ? ch_ctrl[ch_off[2:1]] : ch_data[ch_off[2:1]];
                end
            end
        endcase
    end

    // read data register; unmapped reads answer zero
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            PRDATA <= 32'h00000000;
        end else if (rd_setup) begin
            PRDATA <= {`FSR_UPPER_ZERO, mapped ? live : `FSR_BYTE_ZERO};
        end
    end

    // high-side flag value seen by the current read, so only a reported 1 is cleared
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            hs_seen <= 1'b0;
        end else if (rd_setup) begin
            hs_seen <= highside_any_fault;
        end
    end

    // power-up flag: clear only what the read reported, a new event wins
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            power_up_flag <= `FSR_POWER_UP_RESET;
        end else if (POWER_ON_EVENT) begin
            power_up_flag <= 1'b1;
        end else if (rd_access && idx == `FSR_IDX_SUMMARY && PRDATA[`FSR_BIT_POWER_UP]) begin
            power_up_flag <= 1'b0;
        end
    end

    // high-side summary latches; cleared by a read of register 6
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            highside_any_fault <= 1'b0;
        end else if (hs_event) begin
            highside_any_fault <= 1'b1;
        end else if (rd_access && mapped && idx == `FSR_IDX_RELAY && hs_seen) begin
            highside_any_fault <= 1'b0;
        end
    end

    // watchdog error latches while out of range; clears on read
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            watchdog_latched_error <= 1'b0;
        end else if (!watchdog_in_range) begin
            watchdog_latched_error <= 1'b1;
        end else if (rd_access && idx == `FSR_IDX_WD_CTRL && PRDATA[`FSR_BIT_WD_ERROR]) begin
            watchdog_latched_error <= 1'b0;
        end
    end

    // watchdog enable, the one bit software writes
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            WATCHDOG_ENABLE <= `FSR_WD_EN_RESET;
        end else if (wr_access && mapped && idx == `FSR_IDX_WD_CTRL) begin
            WATCHDOG_ENABLE <= PWDATA[`FSR_BIT_WD_EN];
        end
    end

    // speed counter; clear beats enable, so a conflict leaves it at zero
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            speed_count <= `FSR_COUNT_RESET;
            speed_counter_overflow <= 1'b0;
        end else if (COUNT_CLEAR_CTL) begin
            speed_count <= `FSR_COUNT_RESET;
            speed_counter_overflow <= 1'b0;
        end else if (COUNT_ENABLE_CTL && SPEED_PULSE) begin
            speed_count <= speed_count + `FSR_COUNT_STEP;
            if (speed_count == `FSR_COUNT_MAX) begin
                speed_counter_overflow <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RESET);

    sequence s_read_of(fsr_idx_t i);
        rd_setup && mapped && idx == i;
    endsequence

    a_fail_summary_read: assert property (
        s_read_of(`FSR_IDX_SUMMARY) |=> PRDATA[0] == $past(ls_fail))
        else $error("low-side summary bit wrong");
    a_power_up_clear: assert property (
        rd_access && idx == `FSR_IDX_SUMMARY && PRDATA[`FSR_BIT_POWER_UP] && !POWER_ON_EVENT
        |=> !power_up_flag)
        else $error("power-up flag not cleared by read");
    a_power_up_set: assert property (
        POWER_ON_EVENT |=> power_up_flag)
        else $error("power-up flag not set");
    a_comparator_levels: assert property (
        s_read_of(`FSR_IDX_SUMMARY) |=> PRDATA[2] == $past(RELAY_COMPARATOR_A)
                                       && PRDATA[7] == $past(RELAY_COMPARATOR_B))
        else $error("comparator levels wrong");
    a_ext_reset_bit: assert property (
        s_read_of(`FSR_IDX_SUMMARY) |=> PRDATA[3] == $past(RESET_PIN_EXT_LOW))
        else $error("external reset bit wrong");
    a_ov_replica_read: assert property (
        s_read_of(`FSR_IDX_RELAY) |=> PRDATA[`FSR_BIT_OV_REPLICA] == $past(BAT_OVERVOLTAGE))
        else $error("overvoltage replica wrong");
    a_hs_fault_set: assert property (
        hs_event |=> highside_any_fault [*2] or (highside_any_fault ##1 1'b1))
        else $error("high-side summary not set");
    a_hs_fault_hold: assert property (
        highside_any_fault && !(rd_access && idx == `FSR_IDX_RELAY) |=> highside_any_fault)
        else $error("high-side summary dropped without read");
    a_lamp_flags: assert property (
        s_read_of(`FSR_IDX_MISC) |=> PRDATA[1:0] == $past({OPEN_LOAD_FLAG[8],
                                                         SHORT_TO_BATTERY_FLAG[8]}))
        else $error("lamp driver flags wrong");
    a_counter_conflict: assert property (
        s_read_of(`FSR_IDX_MISC) |=> PRDATA[`FSR_BIT_CONFLICT] ==
                                     $past(COUNT_ENABLE_CTL && COUNT_CLEAR_CTL))
        else $error("counter conflict bit wrong");
    a_count_overflow: assert property (
        speed_count == `FSR_COUNT_MAX && COUNT_ENABLE_CTL && SPEED_PULSE && !COUNT_CLEAR_CTL
        |=> speed_counter_overflow && speed_count == `FSR_COUNT_RESET)
        else $error("overflow past 256 missed");
    a_watchdog_status: assert property (
        s_read_of(`FSR_IDX_WATCHDOG) |=> PRDATA[3:0] == $past({WATCHDOG_ENABLE &&
                                         WATCHDOG_TIMING_OK, WATCHDOG_TRACK_COUNT}))
        else $error("watchdog status wrong");
    a_watchdog_latch: assert property (
        !watchdog_in_range |=> watchdog_latched_error)
        else $error("watchdog error not latched");
endmodule

// >>> fsr_apb_master.sv
/*
 * apb master standing in for the controller that reads the status bank.
 * assumes a single SYS_CLK domain and a slave that answers with pready.
 */
`timescale 1ns/1ps

module fsr_apb_master (
    input wire logic sys_clk, // bus clock
    output logic psel, // select
    output logic penable, // access phase
    output logic pwrite, // direction, high for write
    output fsr_pkg::fsr_addr_t paddr, // byte address
    output logic [31:0] pwdata, // write data
    input wire logic [31:0] prdata, // read data
    input wire logic pready, // slave ready
    input wire logic pslverr // slave error
);
    import fsr_pkg::*;

    // idle bus at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
    end

    // one transfer; the request is held until pready is seen at an edge
    task automatic xfer(input logic wr, input fsr_addr_t a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        // no cycle count is assumed; only the bench watchdog ends a hung wait
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released lines show the inverse so stale values cannot pass
        paddr <= ~a;
        pwdata <= ~wd;
    endtask
endmodule

// >>> tb.sv
/*
 * self-checking bench of the fault and status bank: apb reads and
 * writes with expected values worked out from the bit map.
 * assumes fsr_apb_master as bus driver and monitors driven as levels.
 */
`timescale 1ns/1ps
`include "fsr_map.svh"

module tb;
    import fsr_pkg::*;

    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, wd_enable;
    fsr_addr_t paddr;
    logic [31:0] pwdata, prdata, d;
    logic e;
    int n_errors = 0;
    int n_compared = 0;
    logic [9:0] open_load = '0, short_bat = '0;
    logic [6:0] relay = '0; // mr oc, stg, forced, leak, pr forced, stg, oc
    logic power_on = 0, ext_low = 0, uv = 0, ov = 0, cmp_a = 0, cmp_b = 0;
    logic kline = 0, otemp = 0, cnt_en = 0, count_clear_ctl = 0, pulse = 0, wd_ok = 0;
    logic [2:0] wd_cnt = '0;
    logic [1:0] sup_fault = '0, sup_oc = '0;
    logic [3:0][8:0] ch_data = '0;
    logic [3:0][3:0] ch_valid = '0;
    logic [3:0] ch_new = '0, ch_stand = '0, ch_sb = '0, ch_fault = '0, ch_oc = '0;

    always #2.5 sys_clk = ~sys_clk;

    fsr_apb_master m (.sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    fsr_status_bank uut (.SYS_CLK(sys_clk), .RESET(reset), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .OPEN_LOAD_FLAG(open_load), .SHORT_TO_BATTERY_FLAG(short_bat),
        .POWER_ON_EVENT(power_on), .RESET_PIN_EXT_LOW(ext_low), .BAT_UNDERVOLTAGE(uv),
        .BAT_OVERVOLTAGE(ov), .RELAY_COMPARATOR_A(cmp_a), .RELAY_COMPARATOR_B(cmp_b),
        .MASTER_RELAY_OVERCURRENT(relay[0]), .MASTER_RELAY_SHORT_GROUND(relay[1]),
        .MASTER_GATE_FORCED_OFF(relay[2]), .MASTER_RELAY_LEAKAGE(relay[3]),
        .PUMP_GATE_FORCED_OFF(relay[4]), .PUMP_RELAY_SHORT_GROUND(relay[5]),
        .PUMP_RELAY_OVERCURRENT(relay[6]), .KLINE_CURRENT_LIMIT(kline),
        .OVERTEMPERATURE_FLAG(otemp), .COUNT_ENABLE_CTL(cnt_en), .COUNT_CLEAR_CTL(count_clear_ctl),
        .SPEED_PULSE(pulse), .WATCHDOG_TRACK_COUNT(wd_cnt), .WATCHDOG_TIMING_OK(wd_ok),
        .SUPPLY_OPEN_OR_SHORT(sup_fault), .SUPPLY_OVERCURRENT(sup_oc),
        .CHANNEL_SENSOR_DATA(ch_data), .SENSOR_VALID_BITS_FIELD(ch_valid),
        .CHANNEL_NEW(ch_new), .CHANNEL_STANDSTILL(ch_stand), .CHANNEL_SHORT_BAT(ch_sb),
        .CHANNEL_FAULT(ch_fault), .CHANNEL_OVERCURRENT(ch_oc), .WATCHDOG_ENABLE(wd_enable));

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rd(input fsr_idx_t idx, output logic [31:0] v);
        logic err;
        m.xfer(1'b0, {idx, 2'b00}, 32'h00000000, v, err);
    endtask

    task automatic rdc(input fsr_idx_t idx, input logic [31:0] exp);
        logic [31:0] v;
        rd(idx, v);
        chk(v, exp);
    endtask

    // one-cycle wheel edge, then a quiet cycle
    task automatic spin(input int n);
        repeat (n) begin
            pulse <= 1'b1;
            tick(1);
            pulse <= 1'b0;
            tick(1);
        end
    endtask

    task automatic end_sim();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // a hang is cut short well past the roughly 790 cycles the run needs
    initial begin
        #100000;
        n_errors++;
        end_sim();
    end

    initial begin
        tick(20);
        reset <= 1'b0;
        tick(1);
        // power-up flag after reset, cleared by the read, set again by an event
        rdc(`FSR_IDX_SUMMARY, 32'h02);
        rdc(`FSR_IDX_SUMMARY, 32'h00);
        power_on <= 1'b1;
        tick(1);
        power_on <= 1'b0;
        tick(2);
        rdc(`FSR_IDX_SUMMARY, 32'h02);
        // low-side flags: output 3 open, output 6 short, both lamps
        open_load <= 10'h104;
        short_bat <= 10'h220;
        tick(2);
        rdc(`FSR_IDX_LS_LOW, 32'h20);
        rdc(`FSR_IDX_LS_HIGH, 32'h04);
        rdc(`FSR_IDX_MISC, 32'h06);
        rdc(`FSR_IDX_SUMMARY, 32'h01);
        open_load <= 10'h100;
        short_bat <= 10'h000;
        tick(2);
        rdc(`FSR_IDX_SUMMARY, 32'h00);
        open_load <= 10'h000;
        // live summary bits and the overvoltage replica
        cmp_a <= 1'b1;
        ext_low <= 1'b1;
        ov <= 1'b1;
        tick(2);
        rdc(`FSR_IDX_SUMMARY, 32'h2c);
        rdc(`FSR_IDX_RELAY, 32'h80);
        cmp_a <= 1'b0;
        ext_low <= 1'b0;
        ov <= 1'b0;
        cmp_b <= 1'b1;
        uv <= 1'b1;
        tick(2);
        rdc(`FSR_IDX_SUMMARY, 32'h90);
        rdc(`FSR_IDX_RELAY, 32'h00);
        cmp_b <= 1'b0;
        uv <= 1'b0;
        // each relay flag; faults latch the high-side summary until idx 6 read
        for (int k = 0; k < 7; k++) begin
            relay <= 7'h01 << k;
            tick(2);
            rdc(`FSR_IDX_RELAY, 32'h01 << k);
            relay <= 7'h00;
            tick(2);
            rdc(`FSR_IDX_SUMMARY, 32'h40);
            rdc(`FSR_IDX_RELAY, 32'h00);
            rdc(`FSR_IDX_SUMMARY, 32'h00);
        end
        // speed counter, conflict, overflow past 256
        cnt_en <= 1'b1;
        spin(3);
        rdc(`FSR_IDX_COUNT, 32'h03);
        count_clear_ctl <= 1'b1;
        tick(2);
        rd(`FSR_IDX_MISC, d);
        chk(d & 32'h20, 32'h20);
        count_clear_ctl <= 1'b0;
        tick(1);
        spin(255);
        rd(`FSR_IDX_MISC, d);
        chk(d & 32'h80, 32'h00);
        rdc(`FSR_IDX_COUNT, 32'hff);
        spin(1);
        rdc(`FSR_IDX_COUNT, 32'h00);
        rd(`FSR_IDX_MISC, d);
        chk(d & 32'h80, 32'h80);
        kline <= 1'b1;
        otemp <= 1'b1;
        tick(2);
        rd(`FSR_IDX_MISC, d);
        chk(d & 32'h50, 32'h50);
        // watchdog: disabled status reads 0 and the error latches
        wd_cnt <= 3'b101;
        wd_ok <= 1'b1;
        tick(2);
        rdc(`FSR_IDX_WATCHDOG, 32'h05);
        m.xfer(1'b1, {`FSR_IDX_WD_CTRL, 2'b00}, 32'h00000010, d, e);
        tick(1);
        chk({31'h0, wd_enable}, 32'h1);
        rdc(`FSR_IDX_WD_CTRL, 32'h90);
        rdc(`FSR_IDX_WD_CTRL, 32'h10);
        sup_fault <= 2'b10;
        sup_oc <= 2'b01;
        tick(2);
        rdc(`FSR_IDX_WATCHDOG, 32'h6d);
        wd_ok <= 1'b0;
        tick(2);
        rdc(`FSR_IDX_WATCHDOG, 32'h65);
        wd_ok <= 1'b1;
        tick(2);
        rdc(`FSR_IDX_WD_CTRL, 32'h90);
        rdc(`FSR_IDX_WD_CTRL, 32'h10);
        // sensor channels one and two, channel fault word
        ch_data[0] <= 9'h1a5;
        ch_valid[0] <= 4'hc;
        ch_new[0] <= 1'b1;
        ch_sb[0] <= 1'b1;
        ch_data[1] <= 9'h05a;
        ch_valid[1] <= 4'h3;
        ch_stand[1] <= 1'b1;
        ch_fault <= 4'h3;
        ch_oc <= 4'h8;
        tick(2);
        rdc(`FSR_IDX_CH_FIRST, 32'ha5);
        rdc(`FSR_IDX_CH_FIRST + 6'h01, 32'hcb);
        rdc(`FSR_IDX_CH_FIRST + 6'h02, 32'h5a);
        rdc(`FSR_IDX_CH_FIRST + 6'h03, 32'h34);
        rdc(`FSR_IDX_WS_SUPPLY, 32'h83);
        // refused accesses and a write to a read-only word
        m.xfer(1'b0, 8'h40, 32'h00000000, d, e);
        chk(d, 32'h00000000);
        chk({31'h0, e}, 32'h1);
        m.xfer(1'b0, 8'h01, 32'h00000000, d, e);
        chk({31'h0, e}, 32'h1);
        m.xfer(1'b1, {`FSR_IDX_COUNT, 2'b00}, 32'h000000ff, d, e);
        rdc(`FSR_IDX_COUNT, 32'h00);
        end_sim();
    end
endmodule
